// [src/dram_ctrl_defs.svh]
// timing counts and field positions for the dram host controller
`ifndef DRAM_CTRL_DEFS_SVH
`define DRAM_CTRL_DEFS_SVH

// ****************************************************************
// clock and conversion
// ****************************************************************
`define CLK_MHZ          100
`define CYC_MIN(ns)      (((ns) * `CLK_MHZ + 999) / 1000)
`define CYC_MAX(ns)      (((ns) * `CLK_MHZ) / 1000)

// ****************************************************************
// strobe timing in ns, slowest speed grade
// ****************************************************************
`define T_RP_NS          150
`define T_RAS_NS         200
`define T_RCD_NS         30
`define T_RAC_NS         200
`define T_CWL_NS         100
`define T_CP_NS          105
`define T_RAS_MAX_NS     10000
`define T_REF_NS         2000000
`define T_INIT_NS        100000

// ****************************************************************
// derived cycle counts
// ****************************************************************
`define RP_CYC           `CYC_MIN(`T_RP_NS)
`define RAS_CYC          `CYC_MIN(`T_RAS_NS)
`define RCD_CYC          `CYC_MIN(`T_RCD_NS)
`define RAC_CYC          `CYC_MIN(`T_RAC_NS)
`define CWL_CYC          `CYC_MIN(`T_CWL_NS)
`define CP_CYC           `CYC_MIN(`T_CP_NS)
`define RAS_MAX_CYC      `CYC_MAX(`T_RAS_MAX_NS)
`define PAGE_LIMIT_CYC   (`RAS_MAX_CYC / 2)
`define SYNC_LAT         4
`define COL_WAIT_CYC     (`RAC_CYC - `RCD_CYC + `SYNC_LAT)
`define REF_ROWS         128
`define REF_INT_CYC      `CYC_MAX(`T_REF_NS / `REF_ROWS)
`define INIT_PAUSE_CYC   `CYC_MIN(`T_INIT_NS)
`define INIT_RAS_CYCLES  8

// ****************************************************************
// address fields
// ****************************************************************
`define MA_W             7
`define ROW_LSB          0
`define COL_LSB          7
`define WORD_ADDR_W      14

`endif

// [src/dram_ctrl_pkg.sv]
// types shared by the dram host controller modules
package dram_ctrl_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ROW  = 3'h1,
      ST_COL  = 3'h3,
      ST_WRT  = 3'h2,
      ST_CPRE = 3'h6,
      ST_PAGE = 3'h7,
      ST_PRE  = 3'h5,
      ST_REF  = 3'h4
   } ctrl_state_e;

   typedef enum logic [1:0] {
      PH_PAUSE = 2'h0,
      PH_WARM  = 2'h1,
      PH_RUN   = 2'h3
   } sched_phase_e;

   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_WRITE = 2'h1,
      OP_RMW   = 2'h2
   } op_e;

endpackage : dram_ctrl_pkg

// [src/refresh_if.sv]
// refresh request carrier between scheduler and strobe sequencer
`timescale 1ns/100ps
interface refresh_if;
   logic ref_req;
   logic ref_ack;
   logic init_done;

   modport sched (output ref_req, output init_done, input ref_ack);
   modport ctrl  (input ref_req, input init_done, output ref_ack);
endinterface : refresh_if

// [src/refresh_sched.sv]
// power-up pause, warm-up cycles and periodic refresh requests
`timescale 1ns/100ps
`include "dram_ctrl_defs.svh"
module refresh_sched #(
   parameter int unsigned INIT_PAUSE_CYC = `INIT_PAUSE_CYC
) (
   input  wire logic clock,
   input  wire logic nrst,
   refresh_if.sched  rif
);

   typedef struct packed {
      dram_ctrl_pkg::sched_phase_e phase;
      logic [15:0]                 cnt;
      logic [3:0]                  done_cnt;
      logic                        ref_req;
      logic                        init_done;
   } sched_s;

   sched_s r_ff;
   sched_s nxt_r;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      nxt_r = r_ff;
      nxt_r.cnt = r_ff.cnt + 16'h0001;
      if (rif.ref_ack) begin
         nxt_r.ref_req = 1'b0;
      end
      unique case (r_ff.phase)
         dram_ctrl_pkg::PH_PAUSE: begin
            if (r_ff.cnt == 16'(INIT_PAUSE_CYC - 1)) begin
               nxt_r.phase = dram_ctrl_pkg::PH_WARM;
               nxt_r.cnt   = 16'h0000;
            end
         end
         dram_ctrl_pkg::PH_WARM: begin
            nxt_r.cnt = 16'h0000;
            if (rif.ref_ack) begin
               nxt_r.done_cnt = r_ff.done_cnt + 4'h1;
            end
            if (nxt_r.done_cnt == 4'(`INIT_RAS_CYCLES)) begin
               nxt_r.phase     = dram_ctrl_pkg::PH_RUN;
               nxt_r.init_done = 1'b1;
            end else if (!r_ff.ref_req && !rif.ref_ack) begin
               nxt_r.ref_req = 1'b1;
            end
         end
         dram_ctrl_pkg::PH_RUN: begin
            if (r_ff.cnt == 16'(`REF_INT_CYC - 1)) begin
               nxt_r.cnt     = 16'h0000;
               nxt_r.ref_req = 1'b1;
            end
         end
         default: begin
            nxt_r.phase = dram_ctrl_pkg::PH_PAUSE;
            nxt_r.cnt   = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r_ff <= '{phase: dram_ctrl_pkg::PH_PAUSE, default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign rif.ref_req   = r_ff.ref_req;
   assign rif.init_done = r_ff.init_done;

endmodule : refresh_sched

// [src/dram_host_ctrl.sv]
// strobe sequencer that drives a 16k x 1 multiplexed-address dram
`timescale 1ns/100ps
`include "dram_ctrl_defs.svh"
module dram_host_ctrl #(
   parameter int unsigned INIT_PAUSE_CYC = `INIT_PAUSE_CYC
) (
   input  wire logic                       clock,
   input  wire logic                       nrst,
   input  wire logic                       req_valid,
   input  wire dram_ctrl_pkg::op_e         req_op,
   input  wire logic [`WORD_ADDR_W-1:0]    req_addr,
   input  wire logic                       req_wdata,
   output logic                            req_ready,
   output logic                            rsp_valid,
   output logic                            rsp_rdata,
   output logic                            init_done,
   output logic                            ras_n,
   output logic                            cas_n,
   output logic                            we_n,
   output logic [`MA_W-1:0]                multiplexed_address_lines,
   output logic                            data_to_mem,
   input  wire logic                       data_from_mem
);

   typedef struct packed {
      dram_ctrl_pkg::ctrl_state_e state;
      logic [4:0]                 cnt;
      logic [9:0]                 ras_cnt;
      dram_ctrl_pkg::op_e         op;
      logic [`WORD_ADDR_W-1:0]    addr;
      logic                       wdata;
      logic                       pend;
      logic [`MA_W-1:0]           ref_row;
      logic [`MA_W-1:0]           open_row;
      logic                       ras_n;
      logic                       cas_n;
      logic                       we_n;
      logic [`MA_W-1:0]           ma;
      logic                       d;
      logic                       ready;
      logic                       rsp_valid;
      logic                       rdata;
      logic                       q1;
      logic                       q2;
      logic                       q3;
      logic                       q_stable;
      logic                       ref_ack;
   } ctrl_s;

   ctrl_s            r_ff;
   ctrl_s            nxt_r;
   logic             accept;
   logic             open_col;
   logic             close_col;
   logic [`MA_W-1:0] nxt_row;
   logic [`MA_W-1:0] nxt_col;

   refresh_if rif ();

   refresh_sched #(
      .INIT_PAUSE_CYC (INIT_PAUSE_CYC)
   ) u_sched (
      .clock (clock),
      .nrst  (nrst),
      .rif   (rif)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      nxt_r     = r_ff;
      open_col  = 1'b0;
      close_col = 1'b0;
      accept    = req_valid && r_ff.ready;
      // three-stage pin synchroniser for the data output pin
      nxt_r.q1 = data_from_mem;
      nxt_r.q2 = r_ff.q1;
      nxt_r.q3 = r_ff.q2;
      if (r_ff.q2 == r_ff.q3) begin
         nxt_r.q_stable = r_ff.q3;
      end
      nxt_r.rsp_valid = 1'b0;
      nxt_r.ref_ack   = 1'b0;
      if (r_ff.cnt != 5'h00) begin
         nxt_r.cnt = r_ff.cnt - 5'h01;
      end
      if (!r_ff.ras_n && r_ff.ras_cnt != 10'h3FF) begin
         nxt_r.ras_cnt = r_ff.ras_cnt + 10'h001;
      end
      // a taken request is held until the sequencer can run it
      if (accept) begin
         nxt_r.op    = req_op;
         nxt_r.addr  = req_addr;
         nxt_r.wdata = req_wdata;
         nxt_r.pend  = 1'b1;
      end
      nxt_row = nxt_r.addr[`ROW_LSB +: `MA_W];
      nxt_col = nxt_r.addr[`COL_LSB +: `MA_W];

      unique case (r_ff.state)
         dram_ctrl_pkg::ST_IDLE: begin
            if (rif.ref_req) begin
               // row-strobe-only refresh, column strobe stays high
               nxt_r.state   = dram_ctrl_pkg::ST_REF;
               nxt_r.ref_ack = 1'b1;
               nxt_r.ras_n   = 1'b0;
               nxt_r.ma      = r_ff.ref_row;
               nxt_r.cnt     = 5'(`RAS_CYC - 1);
            end else if (nxt_r.pend) begin
               nxt_r.state    = dram_ctrl_pkg::ST_ROW;
               nxt_r.pend     = 1'b0;
               nxt_r.ras_n    = 1'b0;
               nxt_r.ras_cnt  = 10'h000;
               nxt_r.ma       = nxt_row;
               nxt_r.open_row = nxt_row;
               nxt_r.cnt      = 5'(`RCD_CYC - 1);
            end
         end
         dram_ctrl_pkg::ST_ROW: begin
            if (r_ff.cnt == 5'h00) begin
               open_col = 1'b1;
            end
         end
         dram_ctrl_pkg::ST_COL: begin
            if (r_ff.cnt == 5'h00) begin
               if (r_ff.op != dram_ctrl_pkg::OP_WRITE) begin
                  // sampled only after full access time, never in a write
                  nxt_r.rdata = nxt_r.q_stable;
               end
               if (r_ff.op == dram_ctrl_pkg::OP_RMW) begin
                  // late write after the read bit is out
                  nxt_r.state = dram_ctrl_pkg::ST_WRT;
                  nxt_r.we_n  = 1'b0;
                  nxt_r.d     = r_ff.wdata;
                  nxt_r.cnt   = 5'(`CWL_CYC - 1);
               end else begin
                  close_col = 1'b1;
               end
            end
         end
         dram_ctrl_pkg::ST_WRT: begin
            if (r_ff.cnt == 5'h00) begin
               close_col = 1'b1;
            end
         end
         dram_ctrl_pkg::ST_CPRE: begin
            if (r_ff.cnt == 5'h00) begin
               nxt_r.state = dram_ctrl_pkg::ST_PAGE;
            end
         end
         dram_ctrl_pkg::ST_PAGE: begin
            if (nxt_r.pend && !rif.ref_req && nxt_row == r_ff.open_row
                && r_ff.ras_cnt < 10'(`PAGE_LIMIT_CYC)) begin
               nxt_r.pend = 1'b0;
               open_col   = 1'b1;
            end else begin
               // write line already high here, so read hold is met
               nxt_r.ras_n = 1'b1;
               nxt_r.state = dram_ctrl_pkg::ST_PRE;
               nxt_r.cnt   = 5'(`RP_CYC - 1);
            end
         end
         dram_ctrl_pkg::ST_REF: begin
            nxt_r.cas_n = 1'b1;
            if (r_ff.cnt == 5'h00) begin
               nxt_r.ras_n   = 1'b1;
               nxt_r.ref_row = r_ff.ref_row + 7'h01;
               nxt_r.state   = dram_ctrl_pkg::ST_PRE;
               nxt_r.cnt     = 5'(`RP_CYC - 1);
            end
         end
         dram_ctrl_pkg::ST_PRE: begin
            if (r_ff.cnt == 5'h00) begin
               nxt_r.state = dram_ctrl_pkg::ST_IDLE;
            end
         end
      endcase

      if (open_col) begin
         nxt_r.state = dram_ctrl_pkg::ST_COL;
         nxt_r.ma    = nxt_col;
         nxt_r.cas_n = 1'b0;
         // wait covers both row and column access paths
         nxt_r.cnt   = 5'(`COL_WAIT_CYC - 1);
         if (nxt_r.op == dram_ctrl_pkg::OP_WRITE) begin
            nxt_r.we_n = 1'b0;
            nxt_r.d    = nxt_r.wdata;
         end else begin
            nxt_r.we_n = 1'b1;
         end
      end
      if (close_col) begin
         // column strobe high ends the bit on the data output
         nxt_r.cas_n     = 1'b1;
         nxt_r.we_n      = 1'b1;
         nxt_r.rsp_valid = 1'b1;
         nxt_r.state     = dram_ctrl_pkg::ST_CPRE;
         nxt_r.cnt       = 5'(`CP_CYC - 1);
      end
      nxt_r.ready = (nxt_r.state == dram_ctrl_pkg::ST_IDLE && !nxt_r.pend
                     && rif.init_done && !rif.ref_req)
                    || (nxt_r.state == dram_ctrl_pkg::ST_PAGE && !nxt_r.pend);
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r_ff <= '{state: dram_ctrl_pkg::ST_IDLE, op: dram_ctrl_pkg::OP_READ,
                   ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign rif.ref_ack               = r_ff.ref_ack;
   assign req_ready                 = r_ff.ready;
   assign rsp_valid                 = r_ff.rsp_valid;
   assign rsp_rdata                 = r_ff.rdata;
   assign init_done                 = rif.init_done;
   assign ras_n                     = r_ff.ras_n;
   assign cas_n                     = r_ff.cas_n;
   assign we_n                      = r_ff.we_n;
   assign multiplexed_address_lines = r_ff.ma;
   assign data_to_mem               = r_ff.d;

endmodule : dram_host_ctrl

// [testbench/dram_model.sv]
// behavioural 16k x 1 dram on the controller's memory pins
`timescale 1ns/100ps
module dram_model #(
   parameter int RAC_NS = 200,
   parameter int CAC_NS = 120
) (
   input  wire logic       ras_n,
   input  wire logic       cas_n,
   input  wire logic       we_n,
   input  wire logic [6:0] addr,
   input  wire logic       d,
   output logic            q
);
   logic        mem [16384];
   logic [6:0]  row;
   logic [13:0] word;
   logic        last;
   realtime     t_col;
   realtime     t_row;
   initial begin
      last = 1'b0;
      q = 1'b1;
      t_col = 0.0;
      t_row = 0.0;
   end
   // row latch only, output left as it is
   always @(negedge ras_n) begin
      #1;
      row = addr;
      t_row = $realtime;
   end
   always @(negedge cas_n) begin
      #1;
      word = {addr, row};
      t_col = $realtime;
      if (!we_n) begin
         mem[word] = d;
      end else begin
         // output is not the cell bit until the later of row and column access
         q = ~mem[word];
         if (t_row + RAC_NS > t_col + CAC_NS) begin
            #(t_row + RAC_NS - t_col);
         end else begin
            #(CAC_NS);
         end
         if (!cas_n) begin
            last = mem[word];
            q = last;
         end
      end
   end
   // late write keeps the old bit on the output
   always @(negedge we_n) begin
      #2;
      if (!cas_n && $realtime > t_col + 1.5) mem[word] = d;
   end
   // released output shows the inverse of the last bit
   always @(posedge cas_n) q = ~last;
endmodule : dram_model

// [testbench/dram_host_ctrl_asserts.sv]
// strobe checks for the dram host controller
`timescale 1ns/100ps
`include "dram_ctrl_defs.svh"
module dram_host_ctrl_asserts #(
   parameter int unsigned INIT_PAUSE_CYC = 20
) (
   input wire logic             clock,
   input wire logic             nrst,
   input wire logic             req_ready,
   input wire logic             rsp_valid,
   input wire logic             init_done,
   input wire logic             ras_n,
   input wire logic             cas_n,
   input wire logic             we_n,
   input wire logic [`MA_W-1:0] multiplexed_address_lines,
   input wire logic             data_to_mem
);
   logic [15:0] cyc_ff;
   logic [3:0]  falls_ff;
   logic        ras_d_ff;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cyc_ff <= 16'h0000;
         falls_ff <= 4'h0;
         ras_d_ff <= 1'b1;
      end else begin
         ras_d_ff <= ras_n;
         if (cyc_ff != 16'hFFFF) cyc_ff <= cyc_ff + 16'h0001;
         if (ras_d_ff && !ras_n && falls_ff != 4'hF) falls_ff <= falls_ff + 4'h1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_row_open;
      $fell(ras_n);
   endsequence
   sequence s_read_col;
      $fell(cas_n) && we_n;
   endsequence
   AST_PAUSE_QUIET: assert property (cyc_ff < INIT_PAUSE_CYC - 2 |-> ras_n)
      else $error("row strobe during pause");
   AST_WARMUP_COUNT: assert property ($rose(init_done) |-> falls_ff == 4'h8)
      else $error("warm-up count wrong");
   AST_READY_AFTER_INIT: assert property (!init_done |-> !req_ready)
      else $error("ready before init");
   AST_ROW_HOLD: assert property (s_row_open |-> cas_n ##1 $stable(multiplexed_address_lines) [*2])
      else $error("row address not held");
   AST_COL_AFTER_ROW: assert property ($fell(cas_n) |-> !ras_n && !$past(ras_n, 3))
      else $error("column strobe too early");
   AST_READ_WE_HIGH: assert property (s_read_col |-> we_n [*8])
      else $error("write line dropped in read");
   AST_WRITE_DATA_HELD: assert property (!we_n && !cas_n && !$past(we_n) |-> $stable(data_to_mem))
      else $error("write data moved");
   AST_CAS_WIDTH: assert property ($fell(cas_n) |-> !cas_n [*8])
      else $error("column strobe too short");
   AST_RSP_ON_CAS_RISE: assert property (rsp_valid |-> $rose(cas_n) && we_n)
      else $error("response without column end");
endmodule : dram_host_ctrl_asserts
bind dram_host_ctrl dram_host_ctrl_asserts #(.INIT_PAUSE_CYC(INIT_PAUSE_CYC)) chk (
   .clock(clock), .nrst(nrst), .req_ready(req_ready), .rsp_valid(rsp_valid),
   .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
   .multiplexed_address_lines(multiplexed_address_lines), .data_to_mem(data_to_mem));

// [testbench/tb_top.sv]
// self-checking bench for the dram host controller
`timescale 1ns/100ps
module tb_top;
   logic                clock;
   logic                nrst;
   logic                req_valid;
   dram_ctrl_pkg::op_e  req_op;
   logic [13:0]         req_addr;
   logic                req_wdata, req_ready, rsp_valid, rsp_rdata, init_done, rd;
   logic                ras_n, cas_n, we_n, data_to_mem, data_from_mem;
   logic [6:0]          mux_addr;
   logic [13:0]         addrs [4] = '{14'h0000, 14'h3FFF, 14'h007F, 14'h3F80};
   logic [3:0]          wbits = 4'h5;
   int                  n_mismatch, compares, cycles, ras_falls, rf;
   dram_host_ctrl #(.INIT_PAUSE_CYC(20)) uut (
      .clock(clock), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .multiplexed_address_lines(mux_addr),
      .data_to_mem(data_to_mem), .data_from_mem(data_from_mem));
   dram_model mem0 (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(mux_addr),
      .d(data_to_mem), .q(data_from_mem));
   always #5 clock = ~clock;
   always @(negedge ras_n) if (nrst) ras_falls++;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic access(input dram_ctrl_pkg::op_e op, input logic [13:0] a, input logic wd);
      int n;
      @(negedge clock);
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_wdata = wd;
      n = 0;
      while (req_ready !== 1'b1 && n < 300) begin
         @(negedge clock);
         n++;
      end
      @(negedge clock);
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
      check("response", {15'h0000, rsp_valid}, 16'h0001);
      rd = rsp_rdata;
   endtask : access
   task automatic t_init;
      int n;
      check("reset strobes", {13'h0000, ras_n, cas_n, we_n}, 16'h0007);
      check("reset ready", {14'h0000, req_ready, init_done}, 16'h0000);
      nrst = 1'b1;
      n = 0;
      while (init_done !== 1'b1 && n < 1000) begin
         @(negedge clock);
         n++;
      end
      check("warm-up cycles", 16'(ras_falls), 16'h0008);
      $display("test init done");
   endtask : t_init
   task automatic t_page;
      rf = ras_falls;
      access(dram_ctrl_pkg::OP_WRITE, 14'h0080, 1'b1);
      access(dram_ctrl_pkg::OP_WRITE, 14'h0100, 1'b0);
      check("page row strobes", 16'(ras_falls - rf), 16'h0001);
      access(dram_ctrl_pkg::OP_READ, 14'h0080, 1'b0);
      check("page bit a", {15'h0000, rd}, 16'h0001);
      access(dram_ctrl_pkg::OP_READ, 14'h0100, 1'b1);
      check("page bit b", {15'h0000, rd}, 16'h0000);
      $display("test page done");
   endtask : t_page
   task automatic t_table;
      for (int i = 0; i < 4; i++) access(dram_ctrl_pkg::OP_WRITE, addrs[i], wbits[i]);
      for (int i = 0; i < 4; i++) begin
         access(dram_ctrl_pkg::OP_READ, addrs[i], ~wbits[i]);
         check("table bit", {15'h0000, rd}, {15'h0000, wbits[i]});
      end
      $display("test table done");
   endtask : t_table
   task automatic t_rmw;
      access(dram_ctrl_pkg::OP_RMW, 14'h0000, 1'b0);
      check("rmw old bit", {15'h0000, rd}, 16'h0001);
      access(dram_ctrl_pkg::OP_READ, 14'h0000, 1'b1);
      check("rmw new bit", {15'h0000, rd}, 16'h0000);
      $display("test rmw done");
   endtask : t_rmw
   task automatic t_refresh;
      rf = ras_falls;
      repeat (1600) @(negedge clock);
      check("refresh seen", {15'h0000, ras_falls > rf}, 16'h0001);
      access(dram_ctrl_pkg::OP_READ, 14'h3FFF, 1'b1);
      check("kept bit", {15'h0000, rd}, 16'h0000);
      $display("test refresh done");
   endtask : t_refresh
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      req_valid = 1'b0;
      req_op = dram_ctrl_pkg::OP_READ;
      req_addr = 14'h0000;
      req_wdata = 1'b0;
      repeat (2) @(negedge clock);
      t_init();
      t_page();
      t_table();
      t_rmw();
      t_refresh();
      report_and_stop();
   end
endmodule : tb_top
